// [core/cise_pkg.sv]
// Package of constants, opcodes and carriers for the instruction subset execution block.
package cise_pkg;
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;
  localparam int PROD_W = 32;
  localparam int REG_IDX_W = 4;
  localparam int ACC_GUARD_HI = 39;
  localparam int ACC_SAT_HI = 31;
  localparam logic [2:0] ONE_CYCLE = 3'h1;
  localparam logic [2:0] JUMP_CYCLES = 3'h4;
  localparam logic [1:0] JUMP_DIRECT_WORDS = 2'h2;
  localparam logic [1:0] ONE_WORD = 2'h1;
  localparam logic [2:0] SFR_EXTRA_CYCLES = 3'h1;
  localparam logic [4:0] NO_FIND_RESULT = 5'h10;
  localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

  typedef enum logic [3:0] {
    CISE_NOP,
    CISE_FIND_BIT_CHANGE_LEFT_OP,
    CISE_FIRST_ONE_FROM_MSB_OP,
    CISE_FIRST_ONE_FROM_LSB_OP,
    CISE_JUMP_DIRECT_OP,
    CISE_JUMP_INDIRECT_OP,
    CISE_JUMP_LONG_OP,
    CISE_SHIFT_ONE_OP,
    CISE_SHIFT_BY_REG_OP,
    CISE_SHIFT_BY_LIT_OP,
    CISE_MULTIPLY_ACCUMULATE_OP,
    CISE_SQUARE_ACCUMULATE_OP,
    CISE_DISTANCE_ACCUMULATE_OP,
    CISE_DISTANCE_LOAD_OP,
    CISE_SWAP_REGISTERS_OP
  } cise_op_e;

  // One decoded instruction with its operands read from the register file.
  typedef struct packed {
    cise_op_e op;
    logic [DATA_W-1:0] src_a;
    logic [DATA_W-1:0] src_b;
    logic [DATA_W-1:0] shift_amt;
    logic [REG_IDX_W-1:0] dst_idx;
    logic [REG_IDX_W-1:0] src_idx;
    logic acc_sel;
    logic writeback_en;
    logic [DATA_W-1:0] prefetch_x;
    logic [DATA_W-1:0] prefetch_y;
    logic prefetch_en;
    logic to_default_reg;
    logic to_file_reg;
    logic sfr_access;
  } cise_issue_s;

  typedef struct packed {
    logic carry;
    logic negative;
    logic signed_excess_flag;
    logic zero;
    logic accum_a_overflow;
    logic accum_b_overflow;
    logic either_accum_overflow;
    logic accum_a_clipped;
    logic accum_b_clipped;
    logic either_accum_clipped;
  } cise_flags_s;

  // One result to the register file; a swap uses both write ports.
  typedef struct packed {
    logic wr_en;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [DATA_W-1:0] wr_data;
    logic wr2_en;
    logic [REG_IDX_W-1:0] wr2_idx;
    logic [DATA_W-1:0] wr2_data;
    logic default_reg_en;
    logic file_reg_en;
    logic accumulator_writeback;
    logic [DATA_W-1:0] writeback_data;
    logic prefetch_valid;
    logic [DATA_W-1:0] prefetch_x;
    logic [DATA_W-1:0] prefetch_y;
    logic [DATA_W-1:0] jump_target;
    logic jump_taken;
  } cise_result_s;
endpackage

// [core/cise_exec.sv]
// Execution unit for bit scans, right shifts, jumps, swap and accumulator operations.
//
// Contract
// - The bit-change scan finds the first bit change from the msb side in one cycle and alters only carry.
// - The msb-side first-one scan finds the first set bit from the top in one cycle and alters only carry.
// - The lsb-side first-one scan finds the first set bit from the bottom in one cycle and alters only carry.
// - Every jump takes four cycles, the direct form is two words and the indirect forms one, and no flag changes.
// - A one-bit right shift takes one cycle, writes file, default or destination register and updates C, N, OV and Z.
// - A right shift by a register amount takes one cycle and updates only N and Z.
// - A right shift by a 5-bit literal takes one cycle and updates only N and Z.
// - Multiply-accumulate adds a register product to the chosen accumulator in one cycle with prefetch and writeback.
// - Square-accumulate adds a register squared to the chosen accumulator in one cycle with optional prefetch.
// - Distance-accumulate adds the squared operand to the chosen accumulator in one cycle with prefetch.
// - A read or read-modify-write aimed at a peripheral register outside the core costs one more cycle.
// - Distance-load puts the squared operand into the chosen accumulator, dropping its old value, in one cycle.
`timescale 1ns/1ps
module cise_exec #(
  parameter int DATA_W = cise_pkg::DATA_W,
  parameter int ACC_W = cise_pkg::ACC_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Issue from the decoder.
  input wire logic issue_valid,
  input wire cise_pkg::cise_issue_s issue,
  output logic issue_ready,
  // Results.
  output cise_pkg::cise_result_s result_q,
  output logic result_valid_q,
  output cise_pkg::cise_flags_s flags_q,
  output logic [1:0] words_q,
  output logic [2:0] cycles_q,
  output logic [ACC_W-1:0] acc_a_q,
  output logic [ACC_W-1:0] acc_b_q
);
  if (DATA_W != 16 || ACC_W != 40) begin : g_width_check
    $error("cise_exec supports only a 16-bit word and 40-bit accumulators");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scans.

  logic [4:0] msb_one_pos;
  logic [4:0] lsb_one_pos;
  logic [4:0] change_pos;
  logic [DATA_W-1:0] src;
  assign src = issue.src_a;

  // Positions count from 1 at the searched end; an empty search gives the sentinel.
  // Later iterations overwrite earlier ones, so the last hit is the one nearest that end.
  always_comb begin
    msb_one_pos = cise_pkg::NO_FIND_RESULT;
    lsb_one_pos = cise_pkg::NO_FIND_RESULT;
    change_pos = cise_pkg::NO_FIND_RESULT;
    for (int i = 0; i < DATA_W; i++) begin
      if (src[i]) begin
        msb_one_pos = 5'(DATA_W - i);
      end
    end
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (src[i]) begin
        lsb_one_pos = 5'(i + 1);
      end
    end
    for (int i = 0; i < DATA_W - 1; i++) begin
      if (src[i] != src[DATA_W - 1]) begin
        change_pos = 5'(DATA_W - i);
      end
    end
  end

  logic [4:0] scan_pos;
  logic scan_op;
  assign scan_op = issue.op == cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP ||
                   issue.op == cise_pkg::CISE_FIRST_ONE_FROM_MSB_OP ||
                   issue.op == cise_pkg::CISE_FIRST_ONE_FROM_LSB_OP;
  assign scan_pos = issue.op == cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP ? change_pos :
                    issue.op == cise_pkg::CISE_FIRST_ONE_FROM_MSB_OP ? msb_one_pos : lsb_one_pos;
  // Position 16 is also a real hit, so carry comes from an empty search, not from the sentinel.
  logic scan_none;
  assign scan_none = issue.op == cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP ?
                     (&src || ~|src) : ~|src;

  ////////////////////////////////////////////////////////////////////////////
  // Shifts.

  logic [DATA_W-1:0] shift_one;
  logic [DATA_W-1:0] shift_multi;
  logic [3:0] shift_amt;
  logic shift_big;
  logic shift_one_op;
  logic shift_multi_op;
  assign shift_one = {1'b0, src[DATA_W-1:1]};
  // Any amount of 16 or more empties the word, whatever the upper bits of a register amount hold.
  assign shift_big = |issue.shift_amt[DATA_W-1:4];
  assign shift_amt = issue.shift_amt[3:0];
  assign shift_multi = shift_big ? cise_pkg::WORD_RESET : src >> shift_amt;
  assign shift_one_op = issue.op == cise_pkg::CISE_SHIFT_ONE_OP;
  assign shift_multi_op = issue.op == cise_pkg::CISE_SHIFT_BY_REG_OP ||
                          issue.op == cise_pkg::CISE_SHIFT_BY_LIT_OP;

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator path.

  logic signed [DATA_W-1:0] mul_a;
  logic signed [DATA_W-1:0] mul_b;
  logic signed [cise_pkg::PROD_W-1:0] product;
  logic signed [ACC_W-1:0] prod_ext;
  logic signed [ACC_W-1:0] acc_old;
  logic signed [ACC_W:0] acc_sum;
  logic [ACC_W-1:0] acc_new;
  logic mac_op;
  logic load_op;
  logic acc_ovf;
  logic acc_clip;
  assign load_op = issue.op == cise_pkg::CISE_DISTANCE_LOAD_OP;
  assign mac_op = issue.op == cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP ||
                  issue.op == cise_pkg::CISE_SQUARE_ACCUMULATE_OP ||
                  issue.op == cise_pkg::CISE_DISTANCE_ACCUMULATE_OP || load_op;
  assign mul_a = issue.src_a;
  // Square and both distance forms use one operand twice.
  assign mul_b = issue.op == cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP ? issue.src_b : issue.src_a;
  assign product = mul_a * mul_b;
  assign prod_ext = ACC_W'(product);
  assign acc_old = issue.acc_sel ? acc_b_q : acc_a_q;
  // The load drops the previous accumulator contents.
  assign acc_sum = load_op ? {prod_ext[ACC_W-1], prod_ext} :
                   {acc_old[ACC_W-1], acc_old} + {prod_ext[ACC_W-1], prod_ext};
  assign acc_new = acc_sum[ACC_W-1:0];
  // Overflow into the guard bits, and overflow past the guard bits which clips.
  assign acc_ovf = ~(&acc_new[cise_pkg::ACC_GUARD_HI:cise_pkg::ACC_SAT_HI] |
                     ~|acc_new[cise_pkg::ACC_GUARD_HI:cise_pkg::ACC_SAT_HI]);
  assign acc_clip = acc_sum[ACC_W] != acc_sum[ACC_W-1];
  logic [ACC_W-1:0] acc_sat;
  assign acc_sat = !acc_clip ? acc_new :
                   acc_sum[ACC_W] ? {1'b1, {(ACC_W-1){1'b0}}} : {1'b0, {(ACC_W-1){1'b1}}};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: jumps hold the unit four cycles, peripheral access one extra.

  typedef enum logic [1:0] {CISE_IDLE, CISE_BUSY} cise_state_e;
  cise_state_e state_q;
  cise_state_e state_d;
  logic [2:0] wait_q;
  logic [2:0] wait_d;
  logic [2:0] cost;
  logic jump_op;
  logic take;
  logic ready_q;
  assign jump_op = issue.op == cise_pkg::CISE_JUMP_DIRECT_OP ||
                   issue.op == cise_pkg::CISE_JUMP_INDIRECT_OP ||
                   issue.op == cise_pkg::CISE_JUMP_LONG_OP;
  assign cost = (jump_op ? cise_pkg::JUMP_CYCLES : cise_pkg::ONE_CYCLE) +
                (issue.sfr_access ? cise_pkg::SFR_EXTRA_CYCLES : 3'h0);
  // Ready is registered so the decoder sees no combinational path out of the unit.
  assign issue_ready = ready_q;
  assign take = issue_valid && issue_ready;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      CISE_IDLE: begin
        if (take && cost > cise_pkg::ONE_CYCLE) begin
          state_d = CISE_BUSY;
          wait_d = cost - 3'h2;
        end
      end
      CISE_BUSY: begin
        if (wait_q == 3'h0) begin
          state_d = CISE_IDLE;
        end else begin
          wait_d = wait_q - 3'h1;
        end
      end
      default: state_d = CISE_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and flag updates.

  cise_pkg::cise_result_s res_d;
  cise_pkg::cise_flags_s flg_d;
  always_comb begin
    res_d = '0;
    flg_d = flags_q;
    res_d.wr_idx = issue.dst_idx;
    if (scan_op) begin
      res_d.wr_en = 1'b1;
      res_d.wr_data = DATA_W'(scan_pos);
      flg_d.carry = scan_none;
    end else if (shift_one_op) begin
      res_d.wr_en = !issue.to_default_reg && !issue.to_file_reg;
      res_d.default_reg_en = issue.to_default_reg;
      res_d.file_reg_en = issue.to_file_reg;
      res_d.wr_data = shift_one;
      flg_d.carry = src[0];
      flg_d.negative = 1'b0;
      flg_d.signed_excess_flag = 1'b0;
      flg_d.zero = shift_one == cise_pkg::WORD_RESET;
    end else if (shift_multi_op) begin
      res_d.wr_en = 1'b1;
      res_d.wr_data = shift_multi;
      flg_d.negative = shift_multi[DATA_W-1];
      flg_d.zero = shift_multi == cise_pkg::WORD_RESET;
    end else if (jump_op) begin
      res_d.jump_taken = 1'b1;
      res_d.jump_target = issue.src_a;
    end else if (issue.op == cise_pkg::CISE_SWAP_REGISTERS_OP) begin
      res_d.wr_en = 1'b1;
      res_d.wr_data = issue.src_b;
      res_d.wr2_en = 1'b1;
      res_d.wr2_idx = issue.src_idx;
      res_d.wr2_data = issue.src_a;
    end else if (mac_op) begin
      res_d.prefetch_valid = issue.prefetch_en;
      res_d.prefetch_x = issue.prefetch_x;
      res_d.prefetch_y = issue.prefetch_y;
      res_d.accumulator_writeback = issue.writeback_en &&
                                    issue.op == cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP;
      res_d.writeback_data = issue.acc_sel ? acc_a_q[cise_pkg::ACC_SAT_HI:DATA_W] :
                                             acc_b_q[cise_pkg::ACC_SAT_HI:DATA_W];
      if (issue.acc_sel) begin
        flg_d.accum_b_overflow = acc_ovf;
        flg_d.accum_b_clipped = flags_q.accum_b_clipped | acc_clip;
      end else begin
        flg_d.accum_a_overflow = acc_ovf;
        flg_d.accum_a_clipped = flags_q.accum_a_clipped | acc_clip;
      end
      flg_d.either_accum_overflow = flg_d.accum_a_overflow | flg_d.accum_b_overflow;
      flg_d.either_accum_clipped = flg_d.accum_a_clipped | flg_d.accum_b_clipped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= CISE_IDLE;
      wait_q <= 3'h0;
      ready_q <= 1'b1;
      result_q <= '0;
      result_valid_q <= 1'b0;
      flags_q <= '0;
      words_q <= 2'h0;
      cycles_q <= 3'h0;
      acc_a_q <= cise_pkg::ACC_RESET;
      acc_b_q <= cise_pkg::ACC_RESET;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      ready_q <= state_d == CISE_IDLE;
      result_valid_q <= take;
      if (take) begin
        result_q <= res_d;
        flags_q <= flg_d;
        cycles_q <= cost;
        words_q <= issue.op == cise_pkg::CISE_JUMP_DIRECT_OP ?
                   cise_pkg::JUMP_DIRECT_WORDS : cise_pkg::ONE_WORD;
      end
      if (take && mac_op && !issue.acc_sel) begin
        acc_a_q <= acc_sat;
      end
      if (take && mac_op && issue.acc_sel) begin
        acc_b_q <= acc_sat;
      end
    end
  end
endmodule // cise_exec

// [verification/cise_exec_props.sv]
// Checker of issue, cost and flag behaviour at the execution unit's ports.
`timescale 1ns/1ps
module cise_exec_props #(
  parameter int DATA_W = cise_pkg::DATA_W,
  parameter int ACC_W = cise_pkg::ACC_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Issue side.
  input wire logic issue_valid,
  input wire cise_pkg::cise_issue_s issue,
  input wire logic issue_ready,
  // Result side.
  input wire cise_pkg::cise_result_s result_q,
  input wire logic result_valid_q,
  input wire cise_pkg::cise_flags_s flags_q,
  input wire logic [1:0] words_q,
  input wire logic [2:0] cycles_q,
  input wire logic [ACC_W-1:0] acc_a_q,
  input wire logic [ACC_W-1:0] acc_b_q
);
  logic take;
  logic jump;
  logic scan;
  logic nz_shift;
  assign take = issue_valid && issue_ready;
  assign jump = take && issue.op inside {cise_pkg::CISE_JUMP_DIRECT_OP,
    cise_pkg::CISE_JUMP_INDIRECT_OP, cise_pkg::CISE_JUMP_LONG_OP};
  assign scan = take && issue.op inside {cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP,
    cise_pkg::CISE_FIRST_ONE_FROM_MSB_OP, cise_pkg::CISE_FIRST_ONE_FROM_LSB_OP};
  assign nz_shift = take && issue.op inside {cise_pkg::CISE_SHIFT_BY_REG_OP,
    cise_pkg::CISE_SHIFT_BY_LIT_OP};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A plain jump keeps the unit busy for three cycles after the taking edge.
  sequence s_busy;
    !issue_ready [*3];
  endsequence
  sequence s_free;
    issue_ready;
  endsequence
  a_valid_after_take: assert property (take |=> result_valid_q)
    else $error("no result after a taken op");
  a_valid_only_take: assert property (!take |=> !result_valid_q)
    else $error("result without a taken op");
  a_jump_cost: assert property (jump |=> cycles_q == 3'h4 + {2'h0, $past(issue.sfr_access)})
    else $error("jump cycle cost wrong");
  a_jump_busy_gap: assert property (jump && !issue.sfr_access |=> s_busy ##1 s_free)
    else $error("jump busy gap wrong");
  a_direct_words: assert property (take && issue.op == cise_pkg::CISE_JUMP_DIRECT_OP |=> words_q == 2'h2)
    else $error("direct jump word count wrong");
  a_plain_cost: assert property (take && !jump && !issue.sfr_access |=> cycles_q == 3'h1 && issue_ready && words_q == 2'h1)
    else $error("single cycle op cost wrong");
  a_scan_flags: assert property (scan |=> (flags_q & 10'h1ff) == ($past(flags_q) & 10'h1ff))
    else $error("scan changed a flag other than carry");
  a_shift_nz_flags: assert property (nz_shift |=> (flags_q & 10'h2bf) == ($past(flags_q) & 10'h2bf))
    else $error("shift changed a flag other than n and z");
  a_quiet_flags: assert property (jump || (take && issue.op == cise_pkg::CISE_SWAP_REGISTERS_OP) |=> $stable(flags_q))
    else $error("jump or swap changed a flag");
endmodule // cise_exec_props
bind cise_exec cise_exec_props #(.DATA_W(DATA_W), .ACC_W(ACC_W)) u_props (.mclk(mclk), .rst(rst),
  .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready), .result_q(result_q),
  .result_valid_q(result_valid_q), .flags_q(flags_q), .words_q(words_q), .cycles_q(cycles_q),
  .acc_a_q(acc_a_q), .acc_b_q(acc_b_q));

// [verification/cise_exec_bench.sv]
// Self-checking testbench of the execution unit.
`timescale 1ns/1ps
module cise_exec_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  cise_pkg::cise_issue_s iss = '0;
  logic issue_ready;
  logic result_valid_q;
  cise_pkg::cise_result_s result_q;
  cise_pkg::cise_flags_s flags_q;
  cise_pkg::cise_flags_s f;
  logic [1:0] words_q;
  logic [2:0] cycles_q;
  logic [39:0] acc_a_q;
  logic [39:0] acc_b_q;
  logic [39:0] s;
  int error_cnt = 0;
  int comparisons = 0;
  int gap;
  cise_pkg::cise_op_e sop[9] = '{cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP,
    cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP, cise_pkg::CISE_FIRST_ONE_FROM_MSB_OP,
    cise_pkg::CISE_FIRST_ONE_FROM_MSB_OP, cise_pkg::CISE_FIRST_ONE_FROM_LSB_OP,
    cise_pkg::CISE_FIRST_ONE_FROM_LSB_OP, cise_pkg::CISE_FIRST_ONE_FROM_MSB_OP,
    cise_pkg::CISE_FIRST_ONE_FROM_LSB_OP, cise_pkg::CISE_FIND_BIT_CHANGE_LEFT_OP};
  logic [15:0] sin[9] = '{16'hf000, 16'hffff, 16'h0100, 16'h0000, 16'h0100, 16'h0000,
    16'h0108, 16'h8000, 16'hfffe};
  logic [15:0] spos[9] = '{16'h0005, 16'h0010, 16'h0008, 16'h0010, 16'h0009, 16'h0010,
    16'h0008, 16'h0010, 16'h0010};
  // Carry marks an empty search, so a hit at position 16 must leave it clear.
  logic [8:0] scy = 9'h02a;
  always #5 mclk = ~mclk;
  cise_exec uut (.mclk(mclk), .rst(rst), .issue_valid(issue_valid), .issue(iss),
    .issue_ready(issue_ready), .result_q(result_q), .result_valid_q(result_valid_q),
    .flags_q(flags_q), .words_q(words_q), .cycles_q(cycles_q), .acc_a_q(acc_a_q),
    .acc_b_q(acc_b_q));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Offers one op at a rising edge, holds it to the taking edge, then counts the busy cycles.
  task automatic run(input cise_pkg::cise_op_e op, input logic [15:0] a, input logic [15:0] amt,
      input logic sfr, input logic sel);
    int n;
    n = 0;
    while (issue_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 20) begin
        error_cnt++;
        give_verdict();
      end
    end
    f = flags_q;
    @(posedge mclk);
    iss.op <= op;
    iss.src_a <= a;
    iss.src_b <= (op == cise_pkg::CISE_SWAP_REGISTERS_OP) ? ~a : a;
    iss.shift_amt <= amt;
    iss.sfr_access <= sfr;
    iss.acc_sel <= sel;
    issue_valid <= 1'b1;
    @(posedge mclk);
    issue_valid <= 1'b0;
    #1;
    chk(result_valid_q, 96'h1);
    gap = 0;
    while (issue_ready !== 1'b1 && gap < 8) begin
      @(posedge mclk);
      #1;
      gap++;
    end
    if (issue_ready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    iss.dst_idx = 4'h3;
    iss.src_idx = 4'h5;
    iss.to_default_reg = 1'b1;
    iss.writeback_en = 1'b1;
    iss.prefetch_en = 1'b1;
    iss.prefetch_x = 16'h1111;
    iss.prefetch_y = 16'h2222;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({result_valid_q, flags_q, acc_a_q, acc_b_q}, 96'h0);
    chk(issue_ready, 96'h1);
    for (int i = 0; i < 9; i++) begin
      run(sop[i], sin[i], 16'h0, 1'b0, 1'b0);
      chk({result_q.wr_idx, result_q.wr_data}, {4'h3, spos[i]});
      chk({flags_q.carry, flags_q & 10'h1ff}, {scy[i], f & 10'h1ff});
    end
    run(cise_pkg::CISE_SHIFT_ONE_OP, 16'h8001, 16'h0, 1'b0, 1'b0);
    chk({result_q.wr_data, result_q.default_reg_en}, {16'h4000, 1'b1});
    chk({flags_q.carry, flags_q.negative, flags_q.signed_excess_flag, flags_q.zero}, 4'h8);
    run(cise_pkg::CISE_SHIFT_BY_REG_OP, 16'hf000, 16'h4, 1'b0, 1'b0);
    chk({result_q.wr_data, flags_q}, {16'h0f00, f & 10'h2bf});
    run(cise_pkg::CISE_SHIFT_BY_REG_OP, 16'hf000, 16'h30, 1'b0, 1'b0);
    chk({result_q.wr_data, flags_q.zero}, {16'h0, 1'b1});
    run(cise_pkg::CISE_SHIFT_BY_LIT_OP, 16'h8000, 16'h0, 1'b0, 1'b0);
    chk({result_q.wr_data, flags_q.negative, flags_q.zero}, {16'h8000, 2'h2});
    run(cise_pkg::CISE_SHIFT_BY_LIT_OP, 16'h8000, 16'hf, 1'b0, 1'b0);
    chk({result_q.wr_data, flags_q.negative, flags_q.zero}, {16'h1, 2'h0});
    run(cise_pkg::CISE_SHIFT_ONE_OP, 16'h2, 16'h0, 1'b1, 1'b0);
    chk({cycles_q, gap[3:0]}, {3'h2, 4'h1});
    for (int j = 0; j < 4; j++) begin
      run(j == 1 ? cise_pkg::CISE_JUMP_INDIRECT_OP : j == 2 ? cise_pkg::CISE_JUMP_LONG_OP
        : cise_pkg::CISE_JUMP_DIRECT_OP, 16'h1234, 16'h0, j == 3, 1'b0);
      chk({cycles_q, words_q, gap[3:0], result_q.jump_taken}, {3'h4 + (j == 3),
        (j == 0 || j == 3) ? 2'h2 : 2'h1, 4'h3 + (j == 3), 1'b1});
      chk(flags_q, f);
      chk(result_q.jump_target, 16'h1234);
    end
    run(cise_pkg::CISE_SWAP_REGISTERS_OP, 16'haaaa, 16'h0, 1'b0, 1'b0);
    chk({result_q.wr_idx, result_q.wr_data, result_q.wr2_idx, result_q.wr2_data, flags_q},
      {4'h3, 16'h5555, 4'h5, 16'haaaa, f});
    // Operands of 3 square to 9, and each accumulating form adds one more 9.
    s = 40'h9;
    run(cise_pkg::CISE_DISTANCE_LOAD_OP, 16'h3, 16'h0, 1'b0, 1'b0);
    chk(acc_a_q, s);
    run(cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP, 16'h3, 16'h0, 1'b0, 1'b0);
    chk(acc_a_q, s * 2);
    run(cise_pkg::CISE_SQUARE_ACCUMULATE_OP, 16'h3, 16'h0, 1'b0, 1'b0);
    chk(acc_a_q, s * 3);
    run(cise_pkg::CISE_DISTANCE_ACCUMULATE_OP, 16'h3, 16'h0, 1'b0, 1'b0);
    chk({acc_a_q, flags_q.accum_a_overflow, flags_q.accum_a_clipped}, {s * 4, 2'h0});
    run(cise_pkg::CISE_DISTANCE_LOAD_OP, 16'h3, 16'h0, 1'b0, 1'b0);
    chk({acc_a_q, acc_b_q}, {s, 40'h0});
    run(cise_pkg::CISE_DISTANCE_LOAD_OP, 16'h3, 16'h0, 1'b0, 1'b1);
    chk({acc_a_q, acc_b_q}, {s, s});
    // Each 8000 squared is 2^30: two of them reach the guard bits, 512 of them clip.
    run(cise_pkg::CISE_DISTANCE_LOAD_OP, 16'h8000, 16'h0, 1'b0, 1'b0);
    chk({acc_a_q, flags_q.accum_a_overflow}, {40'h00_4000_0000, 1'b0});
    run(cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP, 16'h8000, 16'h0, 1'b0, 1'b0);
    chk({acc_a_q, flags_q.accum_a_overflow, flags_q.either_accum_overflow,
      flags_q.accum_a_clipped}, {40'h00_8000_0000, 3'h6});
    for (int k = 0; k < 510; k++) begin
      run(cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP, 16'h8000, 16'h0, 1'b0, 1'b0);
    end
    chk({acc_a_q, flags_q.accum_a_clipped, flags_q.either_accum_clipped},
      {40'h7f_ffff_ffff, 2'h3});
    run(cise_pkg::CISE_MULTIPLY_ACCUMULATE_OP, 16'h3, 16'h0, 1'b0, 1'b1);
    chk({acc_b_q, result_q.accumulator_writeback, result_q.writeback_data},
      {40'h12, 1'b1, 16'hffff});
    chk({result_q.prefetch_valid, result_q.prefetch_x, result_q.prefetch_y},
      {1'b1, 16'h1111, 16'h2222});
    // A reset in mid-run must clear everything and leave the unit ready again.
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({result_valid_q, flags_q, acc_a_q, acc_b_q}, 96'h0);
    chk(issue_ready, 96'h1);
    run(cise_pkg::CISE_FIRST_ONE_FROM_LSB_OP, 16'h0002, 16'h0, 1'b0, 1'b0);
    chk({result_q.wr_data, flags_q.carry}, {16'h0002, 1'b0});
    give_verdict();
  end
endmodule // cise_exec_bench
